// File: logic/mnx_map.vh
/*
 * Constants for the multiply / negate / no-operation execution block:
 * register offsets, opcode patterns, phase codes, status bit positions.
 * Assumes it is included once per compile unit by its bare name.
 */
`ifndef MNX_MAP_VH
`define MNX_MAP_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define MNX_OFS_ACCUM 6'h00
`define MNX_OFS_BANK_SEL 6'h04
`define MNX_OFS_STATUS 6'h08
`define MNX_OFS_PROD_LO 6'h0C
`define MNX_OFS_PROD_HI 6'h10
`define MNX_OFS_CTRL 6'h14
`define MNX_OFS_IDX_LO 6'h18
`define MNX_OFS_IDX_HI 6'h1C
`define MNX_OFS_MEM_PTR_LO 6'h20
`define MNX_OFS_MEM_PTR_HI 6'h24
`define MNX_OFS_MEM_DATA 6'h28
`define MNX_OFS_INSTR_LO 6'h2C
`define MNX_OFS_INSTR_HI 6'h30
`define MNX_OFS_EXEC_STATE 6'h34
`define MNX_OFS_RETIRED 6'h38

// ****************************************
// Field positions and reset values
// ****************************************
`define MNX_ST_CARRY 0
`define MNX_ST_DIGIT 1
`define MNX_ST_ZERO 2
`define MNX_ST_SRANGE 3
`define MNX_ST_NEG 4
`define MNX_CTRL_EXT 0
`define MNX_RST_BYTE 8'h00
`define MNX_RST_ADDR 12'h000
`define MNX_RST_WORD 16'h0000

// ****************************************
// Instruction decode
// ****************************************
`define MNX_OPC_MUL_LIT 8'h0D
`define MNX_OPC_MUL_FILE 7'h01
`define MNX_OPC_NEGATE 7'h36
`define MNX_OPC_NOOP_HI 4'hF
`define MNX_OPC_NOOP_ZERO 16'h0000
`define MNX_ACCESS_SPLIT 8'h60
`define MNX_INDEXED_MAX 8'h5F
`define MNX_SFR_BANK 4'hF

// ****************************************
// Operation classes and phases
// ****************************************
`define MNX_CL_NOOP 3'h0
`define MNX_CL_MUL_LIT 3'h1
`define MNX_CL_MUL_FILE 3'h2
`define MNX_CL_NEGATE 3'h3
`define MNX_CL_UNKNOWN 3'h4
`define MNX_PH_IDLE 3'h0
`define MNX_PH_Q1 3'h1
`define MNX_PH_Q2 3'h2
`define MNX_PH_Q3 3'h3
`define MNX_PH_Q4 3'h4

`endif

// File: logic/mnx_exec.v
/*
 * Execution datapath for four single-word core instructions: multiply
 * accumulator by literal, multiply accumulator by file register, negate
 * file register in place, and no-operation. Holds the data memory array,
 * accumulator, bank select, status, product pair and a register port.
 * Assumes one clock, a synchronous active-high reset, and a register
 * master that issues one-cycle strobes and never waits.
 */
// Local design decisions: the placing of the registers and the strobed register port.
// Notes on behaviour
// - Literal multiply: unsigned, 16-bit result into product pair
// - Literal multiply decoded from upper byte 0000 1101
// - Multiplies keep accumulator and all status flags
// - File multiply 0000 001a: unsigned, operands unchanged
// - Bank bit 0 access bank, 1 bank select
// - Extended set, bank bit 0, f<=95: indexed offset
// - Negate 0110 110a: inverted value plus one
// - Negate updates N, range, C, digit carry, Z
`include "mnx_map.vh"

module mnx_exec
(
    input wire clk_sys,
    input wire sys_rst,
    input wire [5:0] reg_addr,
    input wire [7:0] reg_wr_data,
    input wire reg_wr_en,
    input wire reg_rd_en,
    output reg [7:0] reg_rd_data,
    output reg exec_busy,
    output reg exec_done
);

    // ****************************************
    // Address resolution for file operands
    // ****************************************
    function [11:0] mnx_eff_addr;
        input [15:0] word;
        input [3:0] bank;
        input ext_on;
        input [11:0] base;
        begin
            if (word[8])
                mnx_eff_addr = {bank, word[7:0]};
            else if (ext_on && word[7:0] <= `MNX_INDEXED_MAX)
                mnx_eff_addr = base + {4'h0, word[7:0]};
            else if (word[7:0] < `MNX_ACCESS_SPLIT)
                mnx_eff_addr = {4'h0, word[7:0]};
            else
                mnx_eff_addr = {`MNX_SFR_BANK, word[7:0]};
        end
    endfunction

    function [2:0] mnx_classify;
        input [15:0] word;
        begin
            if (word == `MNX_OPC_NOOP_ZERO)
                mnx_classify = `MNX_CL_NOOP;
            else if (word[15:12] == `MNX_OPC_NOOP_HI)
                mnx_classify = `MNX_CL_NOOP;
            else if (word[15:8] == `MNX_OPC_MUL_LIT)
                mnx_classify = `MNX_CL_MUL_LIT;
            else if (word[15:9] == `MNX_OPC_MUL_FILE)
                mnx_classify = `MNX_CL_MUL_FILE;
            else if (word[15:9] == `MNX_OPC_NEGATE)
                mnx_classify = `MNX_CL_NEGATE;
            else
                mnx_classify = `MNX_CL_UNKNOWN;
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    reg [7:0] data_mem [0:4095];
    reg [7:0] accum;
    reg [3:0] bank_select_reg;
    reg [7:0] status;
    reg [7:0] product_low_byte;
    reg [7:0] product_high_byte;
    reg ext_enable;
    reg [11:0] index_base;
    reg [11:0] mem_ptr;
    reg [15:0] instr_word;
    reg [2:0] phase;
    reg [2:0] op_class;
    reg [11:0] op_addr;
    reg [7:0] operand;
    reg [15:0] prod_res;
    reg [7:0] neg_res;
    reg [4:0] neg_flags;
    reg [7:0] retired;

    wire bus_wr_idle;
    wire start;
    wire neg_write;
    wire [7:0] inv_op;
    wire [8:0] neg_sum;
    wire [4:0] nib_sum;
    reg [7:0] next_rd_data;

    assign bus_wr_idle = reg_wr_en && (phase == `MNX_PH_IDLE);
    // Instruction issue is the high-byte write; ignored while busy
    assign start = bus_wr_idle && (reg_addr == `MNX_OFS_INSTR_HI);
    assign neg_write = (phase == `MNX_PH_Q4) &&
        (op_class == `MNX_CL_NEGATE);
    assign inv_op = ~operand;
    assign neg_sum = {1'b0, inv_op} + 9'h001;
    assign nib_sum = {1'b0, inv_op[3:0]} + 5'h01;

    // ****************************************
    // Four-phase sequencer
    // ****************************************
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            phase <= `MNX_PH_IDLE;
            exec_busy <= 1'b0;
            exec_done <= 1'b0;
            retired <= `MNX_RST_BYTE;
        end
        else
        begin
            exec_done <= 1'b0;
            case (phase)
                `MNX_PH_IDLE:
                begin
                    if (start)
                    begin
                        phase <= `MNX_PH_Q1;
                        exec_busy <= 1'b1;
                    end
                end
                `MNX_PH_Q1: phase <= `MNX_PH_Q2;
                `MNX_PH_Q2: phase <= `MNX_PH_Q3;
                `MNX_PH_Q3: phase <= `MNX_PH_Q4;
                `MNX_PH_Q4:
                begin
                    phase <= `MNX_PH_IDLE;
                    exec_busy <= 1'b0;
                    exec_done <= 1'b1;
                    retired <= retired + 8'h01;
                end
                default:
                begin
                    phase <= `MNX_PH_IDLE;
                    exec_busy <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Datapath: decode, read, process
    // ****************************************
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            op_class <= `MNX_CL_NOOP;
            op_addr <= `MNX_RST_ADDR;
            operand <= `MNX_RST_BYTE;
            prod_res <= `MNX_RST_WORD;
            neg_res <= `MNX_RST_BYTE;
            neg_flags <= 5'h00;
        end
        else
        begin
            if (phase == `MNX_PH_Q1)
            begin
                op_class <= mnx_classify(instr_word);
                op_addr <= mnx_eff_addr(instr_word, bank_select_reg,
                    ext_enable, index_base);
            end
            if (phase == `MNX_PH_Q2)
            begin
                if (op_class == `MNX_CL_MUL_LIT)
                    operand <= instr_word[7:0];
                else
                    operand <= data_mem[op_addr];
            end
            if (phase == `MNX_PH_Q3)
            begin
                prod_res <= {8'h00, accum} * {8'h00, operand};
                neg_res <= neg_sum[7:0];
                neg_flags[`MNX_ST_CARRY] <= neg_sum[8];
                neg_flags[`MNX_ST_DIGIT] <= nib_sum[4];
                neg_flags[`MNX_ST_ZERO] <= (neg_sum[7:0] == 8'h00);
                // Range error only when both addends share sign
                neg_flags[`MNX_ST_SRANGE] <= ~inv_op[7] & neg_sum[7];
                neg_flags[`MNX_ST_NEG] <= neg_sum[7];
            end
        end
    end

    // ****************************************
    // Data memory: one write port
    // ****************************************
    // Negate write-back takes the port; a same-cycle host write is lost
    always @(posedge clk_sys)
    begin
        if (neg_write)
            data_mem[op_addr] <= neg_res;
        else if (bus_wr_idle && reg_addr == `MNX_OFS_MEM_DATA)
            data_mem[mem_ptr] <= reg_wr_data;
    end

    // ****************************************
    // Software registers and write-back
    // ****************************************
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            accum <= `MNX_RST_BYTE;
            bank_select_reg <= 4'h0;
            status <= `MNX_RST_BYTE;
            product_low_byte <= `MNX_RST_BYTE;
            product_high_byte <= `MNX_RST_BYTE;
            ext_enable <= 1'b0;
            index_base <= `MNX_RST_ADDR;
            mem_ptr <= `MNX_RST_ADDR;
            instr_word <= `MNX_RST_WORD;
        end
        else
        begin
            // Host writes to software state are dropped while an instruction runs
            if (bus_wr_idle)
            begin
                case (reg_addr)
                    `MNX_OFS_ACCUM: accum <= reg_wr_data;
                    `MNX_OFS_BANK_SEL: bank_select_reg <= reg_wr_data[3:0];
                    `MNX_OFS_STATUS: status <= {3'h0, reg_wr_data[4:0]};
                    `MNX_OFS_PROD_LO: product_low_byte <= reg_wr_data;
                    `MNX_OFS_PROD_HI: product_high_byte <= reg_wr_data;
                    `MNX_OFS_CTRL: ext_enable <= reg_wr_data[`MNX_CTRL_EXT];
                    `MNX_OFS_IDX_LO: index_base[7:0] <= reg_wr_data;
                    `MNX_OFS_IDX_HI: index_base[11:8] <= reg_wr_data[3:0];
                    `MNX_OFS_MEM_PTR_LO: mem_ptr[7:0] <= reg_wr_data;
                    `MNX_OFS_MEM_PTR_HI: mem_ptr[11:8] <= reg_wr_data[3:0];
                    `MNX_OFS_INSTR_LO: instr_word[7:0] <= reg_wr_data;
                    `MNX_OFS_INSTR_HI: instr_word[15:8] <= reg_wr_data;
                    default: ;
                endcase
            end
            if (phase == `MNX_PH_Q4)
            begin
                case (op_class)
                    `MNX_CL_MUL_LIT, `MNX_CL_MUL_FILE:
                    begin
                        // Accumulator and flags untouched
                        product_low_byte <= prod_res[7:0];
                        product_high_byte <= prod_res[15:8];
                    end
                    `MNX_CL_NEGATE:
                        status <= {3'h0, neg_flags};
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    always @*
    begin
        case (reg_addr)
            `MNX_OFS_ACCUM: next_rd_data = accum;
            `MNX_OFS_BANK_SEL: next_rd_data = {4'h0, bank_select_reg};
            `MNX_OFS_STATUS: next_rd_data = status;
            `MNX_OFS_PROD_LO: next_rd_data = product_low_byte;
            `MNX_OFS_PROD_HI: next_rd_data = product_high_byte;
            `MNX_OFS_CTRL: next_rd_data = {7'h00, ext_enable};
            `MNX_OFS_IDX_LO: next_rd_data = index_base[7:0];
            `MNX_OFS_IDX_HI: next_rd_data = {4'h0, index_base[11:8]};
            `MNX_OFS_MEM_PTR_LO: next_rd_data = mem_ptr[7:0];
            `MNX_OFS_MEM_PTR_HI: next_rd_data = {4'h0, mem_ptr[11:8]};
            `MNX_OFS_MEM_DATA: next_rd_data = data_mem[mem_ptr];
            `MNX_OFS_INSTR_LO: next_rd_data = instr_word[7:0];
            `MNX_OFS_INSTR_HI: next_rd_data = instr_word[15:8];
            `MNX_OFS_EXEC_STATE:
                next_rd_data = {1'b0, op_class, exec_busy, phase};
            `MNX_OFS_RETIRED: next_rd_data = retired;
            default: next_rd_data = 8'h00;
        endcase
    end

    // Data valid only in the cycle after the strobe, zero otherwise
    always @(posedge clk_sys)
    begin
        if (sys_rst)
            reg_rd_data <= 8'h00;
        else if (reg_rd_en)
            reg_rd_data <= next_rd_data;
        else
            reg_rd_data <= 8'h00;
    end

endmodule

// File: bench/mnx_exec_properties.sv
/*
 Checker for the multiply/negate/no-op block: instruction timing and
 execution state readback. Sees only the top ports; bound below.
*/
module mnx_exec_chk
(
    input wire clk_sys,
    input wire sys_rst,
    input wire [5:0] reg_addr,
    input wire [7:0] reg_wr_data,
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [7:0] reg_rd_data,
    input wire exec_busy,
    input wire exec_done
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    wire issue = reg_wr_en && reg_addr == 6'h30 && !exec_busy;
    wire st_rd = reg_rd_en && reg_addr == 6'h34;
    reg issue_q;
    // ****************************************
    // Helper: issue seen one cycle back
    // ****************************************
    always @(posedge clk_sys)
    begin
        issue_q <= issue && !sys_rst;
    end
    sequence s_issue;
        issue;
    endsequence
    sequence s_run;
        exec_busy [*4] ##1 (exec_done && !exec_busy);
    endsequence
    sequence s_q1_read;
        s_issue ##1 st_rd;
    endsequence
    property p_issue_walk;
        s_issue |=> s_run;
    endproperty
    property p_done_one;
        exec_done |=> !exec_done;
    endproperty
    property p_done_cause;
        exec_done |-> $past(exec_busy) && !exec_busy;
    endproperty
    property p_busy_len;
        $rose(exec_busy) |-> exec_busy [*4] ##1 !exec_busy;
    endproperty
    property p_busy_cause;
        $rose(exec_busy) |-> issue_q;
    endproperty
    property p_st_busy;
        st_rd && exec_busy |=> reg_rd_data[3];
    endproperty
    property p_st_idle;
        st_rd && !exec_busy |=> reg_rd_data[3:0] == 4'h0;
    endproperty
    property p_st_q1;
        s_q1_read |=> reg_rd_data[3:0] == 4'h9;
    endproperty
    a_issue_walk: assert property (p_issue_walk)
        else $error("issue did not give four busy cycles then done");
    a_done_one: assert property (p_done_one)
        else $error("done longer than one cycle");
    a_done_cause: assert property (p_done_cause)
        else $error("done without busy before it");
    a_busy_len: assert property (p_busy_len)
        else $error("busy not exactly four cycles");
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy without an issue");
    a_st_busy: assert property (p_st_busy)
        else $error("state read misses busy");
    a_st_idle: assert property (p_st_idle)
        else $error("state read not idle");
    a_st_q1: assert property (p_st_q1)
        else $error("first phase not decode");
endmodule
bind mnx_exec mnx_exec_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .exec_busy(exec_busy),
    .exec_done(exec_done));

// File: bench/test_multiply_negate_nop_exec.sv
/*
 Self-checking bench for mnx_exec: a table of instructions run through
 the register port, then refusal and reset cases.
 Assumes the design and the bound checker are compiled with it.
*/
module test_multiply_negate_nop_exec;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed
    {
        logic [15:0] word;
        logic [7:0] acc;
        logic [7:0] bank;
        logic [7:0] ext;
        logic [11:0] maddr;
        logic [7:0] mval;
        logic [15:0] prod;
        logic [7:0] res;
        logic [7:0] st;
    } mnx_row_t;
    // Product preset A55A and status 15 must survive where untouched
    mnx_row_t rows [14] = '{
        '{16'h0DC4, 8'hE2, 8'h0, 8'h0, 12'h0, 8'h0, 16'hAD08, 8'h0, 8'h15},
        '{16'h0DFF, 8'hFF, 8'h0, 8'h0, 12'h0, 8'h0, 16'hFE01, 8'h0, 8'h15},
        '{16'h0305, 8'hC4, 8'h3, 8'h0, 12'h305, 8'hB5, 16'h8A94, 8'hB5, 8'h15},
        '{16'h0220, 8'h10, 8'h0, 8'h0, 12'h020, 8'h10, 16'h0100, 8'h10, 8'h15},
        '{16'h0280, 8'h03, 8'h0, 8'h0, 12'hF80, 8'h02, 16'h0006, 8'h02, 8'h15},
        '{16'h025F, 8'h09, 8'h0, 8'h1, 12'h182, 8'h07, 16'h003F, 8'h07, 8'h15},
        '{16'h0260, 8'h05, 8'h0, 8'h1, 12'hF60, 8'h03, 16'h000F, 8'h03, 8'h15},
        '{16'h6D11, 8'h00, 8'h2, 8'h0, 12'h211, 8'h3A, 16'hA55A, 8'hC6, 8'h10},
        '{16'h6C30, 8'h00, 8'h0, 8'h0, 12'h030, 8'h00, 16'hA55A, 8'h00, 8'h07},
        '{16'h6D40, 8'h00, 8'h1, 8'h0, 12'h140, 8'h80, 16'hA55A, 8'h80, 8'h1A},
        '{16'h6C10, 8'h00, 8'h0, 8'h1, 12'h133, 8'h01, 16'hA55A, 8'hFF, 8'h10},
        '{16'h6E05, 8'h55, 8'h0, 8'h0, 12'h005, 8'h66, 16'hA55A, 8'h66, 8'h15},
        '{16'h0000, 8'h55, 8'h0, 8'h0, 12'h0, 8'h77, 16'hA55A, 8'h77, 8'h15},
        '{16'hF123, 8'h55, 8'h0, 8'h0, 12'h0, 8'h77, 16'hA55A, 8'h77, 8'h15}};
    logic clk_sys;
    logic sys_rst;
    logic [5:0] reg_addr;
    logic [7:0] reg_wr_data;
    logic reg_wr_en;
    logic reg_rd_en;
    logic [7:0] reg_rd_data;
    logic exec_busy;
    logic exec_done;
    int err_count = 0;
    int tests_run = 0;
    mnx_row_t r;
    mnx_exec dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data), .exec_busy(exec_busy),
        .exec_done(exec_done));
    // ****************************************
    // Bus tasks and verdict
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            err_count++;
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wr_data <= v;
        reg_wr_en <= 1'b1;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        #1;
        chk(reg_rd_data, e);
    endtask
    task automatic run(input logic [15:0] w);
        int n;
        n = 0;
        wr(6'h2C, w[7:0]);
        wr(6'h30, w[15:8]);
        #1;
        while (exec_done !== 1'b1 && n < 10)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(n[7:0], 8'h04);
    endtask
    task automatic summarize;
        if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        summarize;
    end
    initial
    begin
        sys_rst = 1'b1;
        reg_addr = 6'h00;
        reg_wr_data = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        wr(6'h18, 8'h23);
        wr(6'h1C, 8'h01);
        for (int i = 0; i < 14; i++)
        begin
            r = rows[i];
            wr(6'h00, r.acc);
            wr(6'h04, r.bank);
            wr(6'h14, r.ext);
            wr(6'h08, 8'h15);
            wr(6'h0C, 8'h5A);
            wr(6'h10, 8'hA5);
            wr(6'h20, r.maddr[7:0]);
            wr(6'h24, {4'h0, r.maddr[11:8]});
            wr(6'h28, r.mval);
            run(r.word);
            rdchk(6'h0C, r.prod[7:0]);
            rdchk(6'h10, r.prod[15:8]);
            rdchk(6'h00, r.acc);
            rdchk(6'h08, r.st);
            rdchk(6'h28, r.res);
        end
        // Accumulator write lands mid-run; it must be dropped
        wr(6'h00, 8'h02);
        wr(6'h2C, 8'h03);
        wr(6'h30, 8'h0D);
        reg_addr <= 6'h34;
        reg_rd_en <= 1'b1;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        #1;
        // Class register still holds the previous no-op during Q1
        chk(reg_rd_data, 8'h09);
        wr(6'h00, 8'h99);
        repeat (6) @(posedge clk_sys);
        rdchk(6'h00, 8'h02);
        rdchk(6'h0C, 8'h06);
        rdchk(6'h38, 8'h0F);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdchk(6'h0C, 8'h00);
        rdchk(6'h00, 8'h00);
        rdchk(6'h08, 8'h00);
        rdchk(6'h34, 8'h00);
        summarize;
    end
endmodule
